// >>> rtl/alarm_ch_if.sv
// settings and state of one alarm channel
// assumes the control block drives settings and the channel drives state
`timescale 1ns/1ps
interface alarm_ch_if;
	logic en, high, closed, flash;
	alarm_pkg::disp_t trip, band;
	logic [11:0] wait_s, mute_s;
	logic cond, active, muted, sw_closed, ann_on, bar_on;
	modport chan(input en, high, closed, flash, trip, band, wait_s, mute_s,
		output cond, active, muted, sw_closed, ann_on, bar_on);
	modport ctl(output en, high, closed, flash, trip, band, wait_s, mute_s,
		input cond, active, muted, sw_closed, ann_on, bar_on);
endinterface : alarm_ch_if

// >>> rtl/alarm_channel.sv
// one alarm channel: trip detection, activation wait, accept mute, flashing
// assumes tick is a one-cycle pulse each second and blink a slow square wave
`timescale 1ns/1ps
module alarm_channel (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// measurement and timing
	input wire alarm_pkg::disp_t disp,
	input wire logic tick,
	input wire logic blink,
	input wire logic accept,
	// settings and state
	alarm_ch_if.chan c
);
	logic cond_r, act_r, sw_r, ann_r, bar_r;
	logic [11:0] wcnt_r, mcnt_r;
	// thresholds widened so the band never wraps
	wire signed [18:0] lo_th = 19'(c.trip) - 19'(c.band);
	wire signed [18:0] hi_th = 19'(c.trip) + 19'(c.band);
	wire signed [18:0] dv = 19'(disp);
	wire set_c = c.high ? (disp >= c.trip) : (disp <= c.trip);
	wire rel_c = c.high ? (dv < lo_th) : (dv > hi_th);
	wire cond_nxt = c.en & (cond_r ? ~rel_c : set_c);
	wire wait_done = wcnt_r >= c.wait_s; // zero wait is immediate
	wire act_nxt = cond_r & (act_r | wait_done);
	wire muted = mcnt_r != 12'd0;
	// wait counter restarts whenever the condition drops
	wire [11:0] wcnt_nxt = (~cond_r | act_r) ? 12'd0 :
		(tick & ~wait_done) ? wcnt_r + 12'd1 : wcnt_r;
	// mute only while active and only with a non-zero time
	wire [11:0] mcnt_nxt = ~act_r ? 12'd0 :
		(accept & (c.mute_s != 12'd0)) ? c.mute_s :
		(tick & muted) ? mcnt_r - 12'd1 : mcnt_r;
	wire out_alarm = act_r & ~muted;
	wire sw_nxt = out_alarm ? c.closed : ~c.closed;
	// annunciator stays lit while muted, flashing if asked
	wire ann_nxt = act_r ? ((c.flash & muted) ? blink : 1'b1) : (c.flash & cond_r & blink);
	wire bar_nxt = ~(c.flash & out_alarm & ~blink);
	// state flops; switch resets to the non-alarm level of the reset polarity
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_r <= 1'b0;
			act_r <= 1'b0;
			wcnt_r <= 12'd0;
			mcnt_r <= 12'd0;
			sw_r <= 1'b1;
			ann_r <= 1'b0;
			bar_r <= 1'b1;
		end else begin
			cond_r <= cond_nxt;
			act_r <= act_nxt;
			wcnt_r <= wcnt_nxt;
			mcnt_r <= mcnt_nxt;
			sw_r <= sw_nxt;
			ann_r <= ann_nxt;
			bar_r <= bar_nxt;
		end
	end
	assign c.cond = cond_r;
	assign c.active = act_r;
	assign c.muted = muted;
	assign c.sw_closed = sw_r;
	assign c.ann_on = ann_r;
	assign c.bar_on = bar_r;
endmodule : alarm_channel

// >>> rtl/alarm_pkg.sv
// constants, types and register map for the dual trip-level alarm block
// assumes a 20 MHz pclk and a signed display value from the measuring side
package alarm_pkg;
	typedef logic signed [17:0] disp_t;
	// apb register offsets
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] DISP_OFF = 8'h04;
	localparam logic [7:0] STAT_OFF = 8'h08;
	localparam logic [7:0] CODE_OFF = 8'h0c;
	localparam logic [7:0] LIMLO_OFF = 8'h10;
	localparam logic [7:0] LIMHI_OFF = 8'h14;
	localparam logic [7:0] TRIP1_OFF = 8'h20;
	localparam logic [7:0] BAND1_OFF = 8'h24;
	localparam logic [7:0] TIME1_OFF = 8'h28;
	localparam logic [7:0] TRIP2_OFF = 8'h30;
	localparam logic [7:0] BAND2_OFF = 8'h34;
	localparam logic [7:0] TIME2_OFF = 8'h38;
	// control register fields
	localparam int CH_BITS = 4;
	localparam int EN_POS = 0;
	localparam int DIR_POS = 1;
	localparam int POL_POS = 2;
	localparam int FLASH_POS = 3;
	localparam int ALT_POS = 8;
	localparam int DACC_POS = 9;
	localparam int TZ_POS = 10;
	localparam int MUT_POS = 16;
	// value limits and reset values
	localparam disp_t TRIP_MIN = -18'sd19999;
	localparam disp_t TRIP_MAX = 18'sd19999;
	localparam disp_t TRIPZ_MIN = -18'sd19990;
	localparam disp_t TRIPZ_MAX = 18'sd99990;
	localparam logic [11:0] TIME_MAX = 12'd3600;
	localparam logic [15:0] CODE_MAX = 16'd9999;
	localparam disp_t LIMLO_RST = TRIP_MIN;
	localparam disp_t LIMHI_RST = TRIP_MAX;
	// timing
	localparam int CLK_NS = 50;
	localparam int SEC_NS = 1000000000;
	localparam int SEC_CYC = SEC_NS / CLK_NS;
	localparam logic [3:0] IDLE_S = 4'd10;
	localparam logic [2:0] LAST_DIG = 3'd4;
	// menu item numbers
	localparam logic [4:0] IT_COND = 5'd0;
	localparam logic [4:0] IT_CH2 = 5'd9;
	localparam logic [4:0] IT_DACC = 5'd17;
	localparam logic [4:0] IT_BTN = 5'd18;
	typedef enum logic [1:0] {BAR_OFF, BAR_SEG, BAR_UP, BAR_DOWN} bar_t;
	typedef enum logic [2:0] {UI_DISP, UI_MENU, UI_MEDIT, UI_CODE, UI_PICK, UI_DEDIT} ui_t;
endpackage : alarm_pkg

// >>> rtl/alarm_top.sv
// dual trip-level alarm logic with apb registers and push-button menus
// assumes synchronous button levels and a display value written over apb
//
// Notes on behaviour
// - two channels, each high or low
// - enable bit keeps other settings intact
// - high alarm trips at display >= trip
// - trip level range and span limits checked
// - polarity picks switch state in alarm
// - high releases below trip minus band
// - activation waits whole seconds, zero immediate
// - annunciator flashes during wait, then bar
// - select button accepts when mute time set
// - accept forces switch off for mute time
// - annunciators still show muted alarm
// - mute time zero to 3600 seconds
// - muted: bar steady, annunciator flashes
// - flash setting gates bar flashing
// - trip marks shown when any enabled
// - single channel draws column to end
// - reversed trips shown as single segments
// - annunciators plus optional alternating identification
// - digit edit: up/down, select, enter stores
// - alarm items sit between conditioning and button
// - direct trip menu with own code
`timescale 1ns/1ps
module alarm_top #(
	parameter int SEC_CYCLES = alarm_pkg::SEC_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// push buttons and option strap
	input wire logic btn_sel,
	input wire logic btn_up,
	input wire logic btn_down,
	input wire logic btn_enter,
	input wire logic alarm_fitted,
	// switch outputs and annunciators
	output logic [1:0] sw_closed,
	output logic [1:0] ann_on,
	// bargraph trip marks
	output logic [1:0] bar_on,
	output logic [3:0] bar_style,
	output logic show_alarm_id,
	// menu view
	output logic [2:0] ui_state,
	output logic [4:0] menu_item,
	output alarm_pkg::disp_t edit_value,
	output logic [2:0] edit_digit
);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic alarm_pkg::disp_t pow10(input logic [2:0] d);
		case (d)
			3'd0: pow10 = 18'sd1;
			3'd1: pow10 = 18'sd10;
			3'd2: pow10 = 18'sd100;
			3'd3: pow10 = 18'sd1000;
			default: pow10 = 18'sd10000;
		endcase
	endfunction : pow10
	function automatic logic time_ok(input alarm_pkg::disp_t v);
		time_ok = (v >= 18'sd0) && (v <= 18'(alarm_pkg::TIME_MAX));
	endfunction : time_ok

	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [1:0] en_r, high_r, closed_r, flash_r;
	alarm_pkg::disp_t trip_r [2];
	alarm_pkg::disp_t band_r [2];
	logic [11:0] wait_r [2];
	logic [11:0] mute_r [2];
	alarm_pkg::disp_t disp_r, limlo_r, limhi_r, ev_r;
	logic alt_r, dacc_r, tz_r, blink_r, tick_r, pslverr_r, show_r;
	logic [15:0] code_r;
	logic [31:0] prdata_r;
	logic [24:0] sec_r;
	logic [3:0] idle_r, bq_r, style_r;
	logic [4:0] item_r;
	logic [2:0] dig_r;
	logic pick_r;
	alarm_pkg::ui_t ui_r;

	// trip level check, span limits stand for the 3.8 and 20.2 mA points
	function automatic logic trip_ok(input alarm_pkg::disp_t v);
		logic in_fmt;
		in_fmt = tz_r ? (v >= alarm_pkg::TRIPZ_MIN && v <= alarm_pkg::TRIPZ_MAX)
			: (v >= alarm_pkg::TRIP_MIN && v <= alarm_pkg::TRIP_MAX);
		trip_ok = in_fmt && v >= limlo_r && v <= limhi_r;
	endfunction : trip_ok

	// ------------------------------------------------------------
	// channels
	// ------------------------------------------------------------
	alarm_ch_if chi [2] ();
	wire [1:0] cond_w, act_w, mute_w, sw_w, ann_w, bar_w;
	wire p_sel, p_up, p_down, p_ent;
	wire accept_w;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch // two independent channels
			assign chi[g].en = en_r[g];
			assign chi[g].high = high_r[g];
			assign chi[g].closed = closed_r[g];
			assign chi[g].flash = flash_r[g];
			assign chi[g].trip = trip_r[g];
			assign chi[g].band = band_r[g];
			assign chi[g].wait_s = wait_r[g];
			assign chi[g].mute_s = mute_r[g];
			assign cond_w[g] = chi[g].cond;
			assign act_w[g] = chi[g].active;
			assign mute_w[g] = chi[g].muted;
			assign sw_w[g] = chi[g].sw_closed;
			assign ann_w[g] = chi[g].ann_on;
			assign bar_w[g] = chi[g].bar_on;
			alarm_channel u_ch (
				.pclk(pclk),
				.presetn(presetn),
				.disp(disp_r),
				.tick(tick_r),
				.blink(blink_r),
				.accept(accept_w),
				.c(chi[g].chan)
			);
		end
	endgenerate

	// ------------------------------------------------------------
	// seconds tick and blink phase
	// ------------------------------------------------------------
	wire sec_end = sec_r == 25'(SEC_CYCLES - 1);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_r <= 25'd0;
			tick_r <= 1'b0;
			blink_r <= 1'b0;
		end else begin
			sec_r <= sec_end ? 25'd0 : sec_r + 25'd1;
			tick_r <= sec_end;
			blink_r <= blink_r ^ sec_end;
		end
	end

	// ------------------------------------------------------------
	// buttons: press edges and chords
	// ------------------------------------------------------------
	assign p_sel = btn_sel & ~bq_r[0];
	assign p_up = btn_up & ~bq_r[1];
	assign p_down = btn_down & ~bq_r[2];
	assign p_ent = btn_enter & ~bq_r[3];
	wire any_p = p_sel | p_up | p_down | p_ent;
	wire chord_direct = (p_sel & btn_up) | (p_up & btn_sel);
	wire chord_menu = (p_sel & btn_enter) | (p_ent & btn_sel);
	wire in_disp = ui_r == alarm_pkg::UI_DISP;
	// select without up or enter in display mode accepts; each channel checks its mute time
	assign accept_w = in_disp & p_sel & ~btn_up & ~btn_enter;

	// ------------------------------------------------------------
	// menu decode
	// ------------------------------------------------------------
	wire item_ch = item_r >= alarm_pkg::IT_CH2;
	wire [4:0] item_rel = item_r - (item_ch ? alarm_pkg::IT_CH2 : 5'd1);
	wire [2:0] item_k = item_rel[2:0];
	wire item_alarm = item_r != alarm_pkg::IT_COND && item_r < alarm_pkg::IT_DACC;
	wire item_num = item_alarm && (item_k == 3'd1 || item_k == 3'd4 ||
		item_k == 3'd5 || item_k == 3'd6);
	// alarm entries exist only with the option fitted
	wire [4:0] item_up = (item_r == alarm_pkg::IT_BTN) ? alarm_pkg::IT_COND :
		(item_r == alarm_pkg::IT_COND && !alarm_fitted) ? alarm_pkg::IT_BTN :
		item_r + 5'd1;
	wire [4:0] item_dn = (item_r == alarm_pkg::IT_COND) ? alarm_pkg::IT_BTN :
		(item_r == alarm_pkg::IT_BTN && !alarm_fitted) ? alarm_pkg::IT_COND :
		item_r - 5'd1;
	wire editable = item_alarm || item_r == alarm_pkg::IT_DACC;
	wire [7:0] flags_c = {en_r[item_ch], high_r[item_ch], closed_r[item_ch],
		flash_r[item_ch], 4'd0};
	wire cur_bit = item_r == alarm_pkg::IT_DACC ? dacc_r :
		item_k == 3'd0 ? flags_c[7] : item_k == 3'd2 ? flags_c[6] :
		item_k == 3'd3 ? flags_c[5] : flags_c[4];
	wire alarm_pkg::disp_t cur_val = !item_num ? 18'(cur_bit) :
		item_k == 3'd1 ? trip_r[item_ch] : item_k == 3'd4 ? band_r[item_ch] :
		item_k == 3'd5 ? 18'(wait_r[item_ch]) : 18'(mute_r[item_ch]);
	// digit editing for numbers, toggling for on/off items
	wire numeric_edit = (ui_r == alarm_pkg::UI_MEDIT && item_num) ||
		ui_r == alarm_pkg::UI_CODE || ui_r == alarm_pkg::UI_DEDIT;
	wire alarm_pkg::disp_t ev_up = numeric_edit ? ev_r + pow10(dig_r) : {17'd0, ~ev_r[0]};
	wire alarm_pkg::disp_t ev_dn = numeric_edit ? ev_r - pow10(dig_r) : {17'd0, ~ev_r[0]};
	wire [2:0] dig_nx = (dig_r == alarm_pkg::LAST_DIG) ? 3'd0 : dig_r + 3'd1;
	wire val_ok = !item_num ? 1'b1 : item_k == 3'd1 ? trip_ok(ev_r) :
		item_k == 3'd4 ? ev_r >= 18'sd0 : time_ok(ev_r);
	// stores taken on enter
	wire st_menu = ui_r == alarm_pkg::UI_MEDIT && p_ent && val_ok;
	wire st_direct = ui_r == alarm_pkg::UI_DEDIT && p_ent && trip_ok(ev_r);
	wire code_match = ev_r == 18'(code_r);
	wire timed_ui = ui_r == alarm_pkg::UI_CODE || ui_r == alarm_pkg::UI_PICK ||
		ui_r == alarm_pkg::UI_DEDIT;

	// ------------------------------------------------------------
	// operator state machine
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ui_r <= alarm_pkg::UI_DISP;
			item_r <= alarm_pkg::IT_COND;
			ev_r <= 18'sd0;
			dig_r <= 3'd0;
			pick_r <= 1'b0;
			idle_r <= 4'd0;
			bq_r <= 4'd0;
		end else begin
			bq_r <= {btn_enter, btn_down, btn_up, btn_sel};
			idle_r <= (!timed_ui || any_p) ? 4'd0 : idle_r + {3'd0, tick_r};
			if (timed_ui && idle_r == alarm_pkg::IDLE_S) begin
				ui_r <= alarm_pkg::UI_DISP; // ten idle seconds leave
			end else begin
				case (ui_r)
					alarm_pkg::UI_DISP: begin
						if (chord_menu) begin
							ui_r <= alarm_pkg::UI_MENU;
							item_r <= alarm_pkg::IT_COND;
						end else if (chord_direct && dacc_r) begin
							ui_r <= (code_r == 16'd0) ? alarm_pkg::UI_PICK : alarm_pkg::UI_CODE;
							ev_r <= 18'sd0;
							dig_r <= 3'd0;
						end
					end
					alarm_pkg::UI_MENU: begin
						if (p_up) item_r <= item_up;
						else if (p_down) item_r <= item_dn;
						else if (p_ent) ui_r <= alarm_pkg::UI_DISP;
						else if (p_sel && editable) begin
							ui_r <= alarm_pkg::UI_MEDIT;
							ev_r <= cur_val;
							dig_r <= 3'd0;
						end
					end
					alarm_pkg::UI_PICK: begin
						if (p_up || p_down) pick_r <= ~pick_r;
						else if (p_ent) ui_r <= alarm_pkg::UI_DISP;
						else if (p_sel) begin
							ui_r <= alarm_pkg::UI_DEDIT;
							ev_r <= trip_r[pick_r];
							dig_r <= 3'd0;
						end
					end
					alarm_pkg::UI_MEDIT, alarm_pkg::UI_CODE, alarm_pkg::UI_DEDIT: begin
						if (p_up) ev_r <= ev_up;
						else if (p_down) ev_r <= ev_dn;
						else if (p_sel) dig_r <= dig_nx;
						else if (p_ent) begin
							case (ui_r)
								alarm_pkg::UI_MEDIT: ui_r <= alarm_pkg::UI_MENU;
								alarm_pkg::UI_DEDIT: ui_r <= alarm_pkg::UI_PICK;
								default: ui_r <= code_match ? alarm_pkg::UI_PICK : alarm_pkg::UI_DISP;
							endcase
						end
					end
					default: ui_r <= alarm_pkg::UI_DISP;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	wire setup = psel & ~penable;
	wire wr = psel & penable & pwrite;
	wire [7:0] a = paddr;
	wire a_ch = a[4];
	wire is_trip = a == alarm_pkg::TRIP1_OFF || a == alarm_pkg::TRIP2_OFF;
	wire is_band = a == alarm_pkg::BAND1_OFF || a == alarm_pkg::BAND2_OFF;
	wire is_time = a == alarm_pkg::TIME1_OFF || a == alarm_pkg::TIME2_OFF;
	wire is_fixed = a == alarm_pkg::CTRL_OFF || a == alarm_pkg::DISP_OFF ||
		a == alarm_pkg::STAT_OFF || a == alarm_pkg::CODE_OFF ||
		a == alarm_pkg::LIMLO_OFF || a == alarm_pkg::LIMHI_OFF;
	wire mapped = is_trip || is_band || is_time || is_fixed;
	wire alarm_pkg::disp_t wv = pwdata[17:0];
	wire alarm_pkg::disp_t wt_w = 18'(pwdata[11:0]);
	wire alarm_pkg::disp_t wm_w = 18'(pwdata[alarm_pkg::MUT_POS +: 12]);
	// bad values are refused and flagged, storage unchanged
	wire bad_val = pwrite && ((is_trip && !trip_ok(wv)) || (is_band && wv < 18'sd0) ||
		(is_time && (!time_ok(wt_w) || !time_ok(wm_w))) ||
		(a == alarm_pkg::CODE_OFF && pwdata[15:0] > alarm_pkg::CODE_MAX));
	wire [31:0] ctrl_rd = {21'd0, tz_r, dacc_r, alt_r,
		flash_r[1], closed_r[1], high_r[1], en_r[1],
		flash_r[0], closed_r[0], high_r[0], en_r[0]};
	wire [31:0] stat_rd = {13'd0, ui_r, item_r, 3'd0, sw_w, mute_w, act_w, cond_w};
	wire [31:0] rd_w = a == alarm_pkg::CTRL_OFF ? ctrl_rd :
		a == alarm_pkg::DISP_OFF ? 32'(disp_r) :
		a == alarm_pkg::STAT_OFF ? stat_rd :
		a == alarm_pkg::CODE_OFF ? {16'd0, code_r} :
		a == alarm_pkg::LIMLO_OFF ? 32'(limlo_r) :
		a == alarm_pkg::LIMHI_OFF ? 32'(limhi_r) :
		is_trip ? 32'(trip_r[a_ch]) : is_band ? 32'(band_r[a_ch]) :
		is_time ? {4'd0, mute_r[a_ch], 4'd0, wait_r[a_ch]} : 32'd0;
	wire wr_ok = wr && mapped && !bad_val;

	// ------------------------------------------------------------
	// register file: apb writes, then operator stores win
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{en_r, high_r, closed_r, flash_r} <= 8'd0;
			trip_r <= '{18'sd0, 18'sd0};
			band_r <= '{18'sd0, 18'sd0};
			wait_r <= '{12'd0, 12'd0};
			mute_r <= '{12'd0, 12'd0};
			{alt_r, dacc_r, tz_r} <= 3'd0;
			disp_r <= 18'sd0;
			code_r <= 16'd0;
			limlo_r <= alarm_pkg::LIMLO_RST;
			limhi_r <= alarm_pkg::LIMHI_RST;
		end else begin
			if (wr_ok) begin
				case (a)
					alarm_pkg::CTRL_OFF: begin
						{flash_r[1], closed_r[1], high_r[1], en_r[1]} <= pwdata[7:4];
						{flash_r[0], closed_r[0], high_r[0], en_r[0]} <= pwdata[3:0];
						alt_r <= pwdata[alarm_pkg::ALT_POS];
						dacc_r <= pwdata[alarm_pkg::DACC_POS];
						tz_r <= pwdata[alarm_pkg::TZ_POS];
					end
					alarm_pkg::DISP_OFF: disp_r <= wv;
					alarm_pkg::CODE_OFF: code_r <= pwdata[15:0];
					alarm_pkg::LIMLO_OFF: limlo_r <= wv;
					alarm_pkg::LIMHI_OFF: limhi_r <= wv;
					alarm_pkg::TRIP1_OFF, alarm_pkg::TRIP2_OFF: trip_r[a_ch] <= wv;
					alarm_pkg::BAND1_OFF, alarm_pkg::BAND2_OFF: band_r[a_ch] <= wv;
					alarm_pkg::TIME1_OFF, alarm_pkg::TIME2_OFF: begin
						wait_r[a_ch] <= pwdata[11:0];
						mute_r[a_ch] <= pwdata[alarm_pkg::MUT_POS +: 12];
					end
					default: ;
				endcase
			end
			if (st_direct) trip_r[pick_r] <= ev_r;
			if (st_menu) begin
				if (item_r == alarm_pkg::IT_DACC) dacc_r <= ev_r[0];
				else begin
					case (item_k)
						3'd0: en_r[item_ch] <= ev_r[0];
						3'd1: trip_r[item_ch] <= ev_r;
						3'd2: high_r[item_ch] <= ev_r[0];
						3'd3: closed_r[item_ch] <= ev_r[0];
						3'd4: band_r[item_ch] <= ev_r;
						3'd5: wait_r[item_ch] <= ev_r[11:0];
						3'd6: mute_r[item_ch] <= ev_r[11:0];
						default: flash_r[item_ch] <= ev_r[0];
					endcase
				end
			end
		end
	end

	// ------------------------------------------------------------
	// trip marks on the right-hand bargraph
	// ------------------------------------------------------------
	wire both_en = &en_r;
	wire normal_pair = ~high_r[0] & high_r[1] & (trip_r[0] <= trip_r[1]);
	function automatic logic [1:0] col_of(input logic hi);
		col_of = hi ? alarm_pkg::BAR_UP : alarm_pkg::BAR_DOWN;
	endfunction : col_of
	wire [1:0] st0 = !en_r[0] ? alarm_pkg::BAR_OFF :
		!both_en ? col_of(high_r[0]) :
		normal_pair ? alarm_pkg::BAR_DOWN : alarm_pkg::BAR_SEG;
	wire [1:0] st1 = !en_r[1] ? alarm_pkg::BAR_OFF :
		!both_en ? col_of(high_r[1]) :
		normal_pair ? alarm_pkg::BAR_UP : alarm_pkg::BAR_SEG;
	// identification alternates with the value on the blink phase
	wire show_nxt = alt_r & (|act_w) & blink_r;

	// ------------------------------------------------------------
	// output and apb answer flops; reads are captured in setup
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			style_r <= 4'd0;
			show_r <= 1'b0;
			prdata_r <= 32'd0;
			pslverr_r <= 1'b0;
		end else begin
			style_r <= {st1, st0};
			show_r <= show_nxt;
			if (setup) begin
				prdata_r <= pwrite ? 32'd0 : rd_w;
				pslverr_r <= !mapped || bad_val;
			end
		end
	end

	assign pready = 1'b1;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r & psel & penable;
	assign sw_closed = sw_w;
	assign ann_on = ann_w;
	assign bar_on = bar_w;
	assign bar_style = style_r;
	assign show_alarm_id = show_r;
	assign ui_state = ui_r;
	assign menu_item = item_r;
	assign edit_value = ev_r;
	assign edit_digit = dig_r;
endmodule : alarm_top

// >>> sim/alarm_top_monitor.sv
// checker for the alarm top: menus, bar style, apb refusals
// assumes it is bound onto alarm_top and sees its ports only
`timescale 1ns/1ps
module alarm_top_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pslverr,
	// buttons
	input wire logic btn_sel,
	input wire logic btn_up,
	input wire logic btn_down,
	input wire logic btn_enter,
	// view
	input wire logic [3:0] bar_style,
	input wire logic [2:0] ui_state,
	input wire logic [4:0] menu_item,
	input wire logic [2:0] edit_digit
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// per channel style fields
	wire [1:0] s1 = bar_style[1:0];
	wire [1:0] s2 = bar_style[3:2];
	wire only_sel = !btn_up && !btn_down && !btn_enter;
	AST_DIG_MAX: assert property (edit_digit <= 3'd4) else $error("digit out of range");
	AST_DIG_STEP: assert property (ui_state == 3'd2 && $rose(btn_sel) && only_sel
		|=> edit_digit == ($past(edit_digit) == 3'd4 ? 3'd0 : $past(edit_digit) + 3'd1))
		else $error("digit step wrong");
	AST_MENU_IN: assert property (ui_state == 3'd0 && $rose(btn_sel) && $rose(btn_enter)
		&& !btn_up && !btn_down |=> ui_state == 3'd1 && menu_item == 5'd0)
		else $error("menu entry wrong");
	AST_ITEM_MAX: assert property (menu_item <= 5'd18) else $error("menu item out");
	AST_DIRECT: assert property (ui_state == 3'd0 && $rose(btn_sel) && $rose(btn_up)
		&& !btn_down && !btn_enter |=> ui_state inside {3'd0, 3'd3, 3'd4})
		else $error("direct entry wrong");
	AST_COLUMN: assert property ((s1 == 2'd0) != (s2 == 2'd0) |-> s1 >= 2'd2 || s2 >= 2'd2)
		else $error("single trip not a column");
	AST_PAIR: assert property (s1 != 2'd0 && s2 != 2'd0
		|-> (s1 == 2'd1 && s2 == 2'd1) || (s1 == 2'd3 && s2 == 2'd2)) else $error("pair style");
	AST_ERR_GATE: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
	AST_UNMAPPED: assert property (psel && penable && paddr == 8'h1c |-> pslverr)
		else $error("unmapped not refused");
	// main scenarios
	cover property (ui_state == 3'd1);
	cover property (s1 == 2'd3 && s2 == 2'd2);
	cover property (pslverr);
endmodule : alarm_top_chk
bind alarm_top alarm_top_chk chk_u (.pclk, .presetn, .psel, .penable, .paddr, .pslverr,
	.btn_sel, .btn_up, .btn_down, .btn_enter, .bar_style, .ui_state, .menu_item, .edit_digit);

// >>> sim/op_panel.sv
// operator panel: turns a one-cycle press request into button levels
// assumes push is driven just after a rising edge of pclk
`timescale 1ns/1ps
module op_panel (
	// clock and request {enter,down,up,sel}
	input wire logic pclk,
	input wire logic [3:0] push,
	// button levels
	output logic [3:0] btn
);
	logic [3:0] btn_r = 4'h0;
	logic [3:0] hold_r = 4'h0;
	assign btn = btn_r;
	// held a few cycles then released, so each press is a fresh edge
	always_ff @(posedge pclk) begin
		if (push != 4'h0) begin
			btn_r <= push;
			hold_r <= 4'h4;
		end else if (hold_r != 4'h0) begin
			hold_r <= hold_r - 4'h1;
		end else begin
			btn_r <= 4'h0;
		end
	end
endmodule : op_panel

// >>> sim/testbench.sv
// self-checking bench for alarm_top over apb and the operator panel
// assumes a one-second tick of 20 cycles via SEC_CYCLES
`timescale 1ns/1ps
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, serr, c_exp;
	logic [3:0] push = 4'h0;
	logic fitted = 1'b1;
	logic [3:0] btn, bar_style;
	logic [1:0] sw_closed, ann_on;
	logic [2:0] ui_state;
	int fail_count = 0;
	int n_tests = 0;
	int trip, band, d;
	logic [7:0] cv[4] = '{8'h00, 8'h03, 8'h13, 8'h31};
	logic [3:0] bv[4] = '{4'h0, 4'h2, 4'h5, 4'hb};
	initial forever #25 pclk = ~pclk;
	alarm_top #(.SEC_CYCLES(20)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .btn_sel(btn[0]), .btn_up(btn[1]),
		.btn_down(btn[2]), .btn_enter(btn[3]), .alarm_fitted(fitted), .sw_closed, .ann_on,
		.bar_on(), .bar_style, .show_alarm_id(), .ui_state, .menu_item(), .edit_value(),
		.edit_digit());
	op_panel panel_u (.pclk, .push, .btn);
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// apb transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k == 50) begin
			chk("pready", 1, 0);
			wrap_up();
		end
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic press(input logic [3:0] m);
		@(posedge pclk);
		push <= m;
		@(posedge pclk);
		push <= 4'h0;
		repeat (8) @(posedge pclk);
	endtask : press
	// condition with hysteresis, high or low sense
	function automatic logic nxt_cond(logic c, int d, int t, int b, int h);
		if (h != 0) return c ? d >= t - b : d >= t;
		return c ? d <= t + b : d <= t;
	endfunction : nxt_cond
	initial begin
		void'($urandom(32'hbc52));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, alarm_pkg::LIMLO_OFF, 0);
		chk("limlo", 32'(alarm_pkg::LIMLO_RST), rd);
		apb(0, 8'h1c, 0);
		chk("unmapped", 1, serr);
		apb(1, alarm_pkg::TRIP1_OFF, 32'd20000);
		chk("trip range", 1, serr);
		apb(1, alarm_pkg::TIME1_OFF, 32'd3601);
		chk("wait range", 1, serr);
		apb(1, alarm_pkg::TIME1_OFF, 32'd3600 << 16);
		chk("mute max", 0, serr);
		trip = $urandom_range(5000, 100);
		band = $urandom_range(200, 0);
		apb(1, alarm_pkg::TRIP1_OFF, trip);
		apb(1, alarm_pkg::BAND1_OFF, band);
		apb(1, alarm_pkg::TIME1_OFF, 0);
		for (int h = 0; h < 2; h++) begin
			apb(1, alarm_pkg::CTRL_OFF, 1 + 2 * h);
			apb(1, alarm_pkg::DISP_OFF, h != 0 ? trip - 400 : trip + 400);
			c_exp = 1'b0;
			repeat (30) begin
				d = trip + $urandom_range(2 * band + 4, 0) - band - 2;
				apb(1, alarm_pkg::DISP_OFF, d);
				c_exp = nxt_cond(c_exp, d, trip, band, h);
				repeat (3) @(posedge pclk);
				apb(0, alarm_pkg::STAT_OFF, 0);
				chk("cond", c_exp, rd[0]);
			end
		end
		apb(1, alarm_pkg::CTRL_OFF, 0);
		apb(0, alarm_pkg::TRIP1_OFF, 0);
		chk("trip kept", trip, rd);
		$display("test hysteresis done");
		// wait of 3 s, interrupted early, then served; mute of 2 s
		apb(1, alarm_pkg::TIME1_OFF, (32'd2 << 16) | 32'd3);
		apb(1, alarm_pkg::DISP_OFF, trip - 400);
		apb(1, alarm_pkg::CTRL_OFF, 3);
		apb(1, alarm_pkg::DISP_OFF, trip);
		repeat (37) @(posedge pclk);
		apb(1, alarm_pkg::DISP_OFF, trip - band - 1);
		apb(1, alarm_pkg::DISP_OFF, trip);
		repeat (14) @(posedge pclk);
		apb(0, alarm_pkg::STAT_OFF, 0);
		chk("wait restart", 0, rd[2]);
		repeat (70) @(posedge pclk);
		chk("switch in alarm", 0, sw_closed[0]);
		press(4'h1);
		chk("switch muted", 1, sw_closed[0]);
		chk("annunciator muted", 1, ann_on[0]);
		repeat (50) @(posedge pclk);
		chk("switch after mute", 0, sw_closed[0]);
		$display("test timing done");
		apb(1, alarm_pkg::TRIP2_OFF, trip + 10);
		for (int i = 0; i < 4; i++) begin
			apb(1, alarm_pkg::CTRL_OFF, cv[i]);
			repeat (4) @(posedge pclk);
			chk("bar style", bv[i], bar_style);
		end
		press(4'h3);
		chk("direct off", 0, ui_state);
		press(4'h9);
		chk("menu entry", 1, ui_state);
		fitted <= 1'b0;
		press(4'h2);
		apb(0, alarm_pkg::STAT_OFF, 0);
		chk("item skip", 18, rd[15:11]);
		fitted <= 1'b1;
		press(4'h2);
		press(4'h2);
		press(4'h2);
		press(4'h1);
		press(4'h1);
		press(4'h2);
		press(4'h8);
		apb(0, alarm_pkg::TRIP1_OFF, 0);
		chk("menu store", trip + 10, rd);
		$display("test menus done");
		wrap_up();
	end
endmodule : testbench
